// ===== tlv_cmd_pkg.sv
package tlv_cmd_pkg;

  // ==========================================================================
  // Command header codes.
  localparam logic [7:0] INS_IDENTITY     = 8'h78;
  localparam logic [7:0] INS_PROFILE      = 8'h10;
  localparam logic [7:0] INS_ENVELOPE     = 8'hC2;
  localparam logic [7:0] INS_FETCH        = 8'h12;
  localparam logic [7:0] INS_TERM_RESP    = 8'h14;
  localparam logic [7:0] INS_RETRIEVE     = 8'hCB;
  localparam logic [7:0] INS_STORE        = 8'hDB;
  localparam logic [7:0] INS_SELECT       = 8'hA4;
  localparam logic [7:0] P_ZERO           = 8'h00;

  // ==========================================================================
  // Block type in the upper bits of P2.
  localparam int         P2_BLK_HI        = 7;
  localparam int         P2_BLK_LO        = 6;
  localparam int         P2_FILE_HI       = 4;
  localparam logic [1:0] BLK_FIRST        = 2'h2;
  localparam logic [1:0] BLK_NEXT         = 2'h0;
  localparam logic [1:0] BLK_RETX         = 2'h1;
  localparam logic [4:0] FILE_CURRENT     = 5'h00;
  localparam int         P2_REF_BIT       = 7;

  // ==========================================================================
  // Tag ranges.
  localparam logic [7:0] TAG_PRIM_LO      = 8'h80;
  localparam logic [7:0] TAG_PRIM_HI      = 8'h9E;
  localparam logic [7:0] TAG_PRIM_EXT     = 8'h9F;
  localparam logic [7:0] TAG_CONS_LO      = 8'hA0;
  localparam logic [7:0] TAG_CONS_HI      = 8'hBE;
  localparam logic [7:0] TAG_CONS_EXT     = 8'hBF;
  localparam logic [7:0] TAG2_LO          = 8'h1F;
  localparam logic [7:0] TAG2_HI          = 8'h7F;
  localparam logic [7:0] TAG2_LONG_LO     = 8'h81;
  localparam logic [7:0] TAG3_HI          = 8'h7F;
  localparam logic [7:0] TAG_LIST         = 8'h5C;

  // ==========================================================================
  // Length coding.
  localparam logic [7:0] LEN_SHORT_MAX    = 8'h7F;
  localparam logic [7:0] LEN_PFX1         = 8'h81;
  localparam logic [7:0] LEN_PFX2         = 8'h82;
  localparam logic [7:0] LEN_PFX3         = 8'h83;

  // ==========================================================================
  // Status words.
  localparam logic [15:0] SW_OK           = 16'h9000;
  localparam logic [15:0] SW_MORE_AVAIL   = 16'h62F1;
  localparam logic [15:0] SW_MORE_AVAIL2  = 16'h62F2;
  localparam logic [15:0] SW_MORE_EXP     = 16'h63F1;
  localparam logic [15:0] SW_MORE_EXP2    = 16'h63F2;
  localparam logic [15:0] SW_BAD_P1P2     = 16'h6A86;
  localparam logic [15:0] SW_BAD_DATA     = 16'h6A80;
  localparam logic [15:0] SW_NOT_SUPP     = 16'h6D00;
  localparam logic [15:0] SW_WRONG_LEN    = 16'h6700;
  localparam logic [15:0] SW_PROACTIVE    = 16'h9100;

  // ==========================================================================
  // Sizes and counts.
  localparam int          NUM_CHAN        = 4;
  localparam int          FIFO_WIDTH      = 8;
  localparam int          FIFO_DEPTH      = 16;
  localparam logic [23:0] OFFSET_RESET    = 24'h000000;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_HDR    = 3'b001,
    ST_DATA   = 3'b011,
    ST_EXEC   = 3'b010,
    ST_ANSWER = 3'b110
  } cmd_state_t;

endpackage

// ===== tlv_byte_fifo.sv
`timescale 1ns/1ps
module tlv_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  // Fill side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  // Flush.
  input  wire logic             flush
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // ==========================================================================
  // Flags and handshakes.
  assign in_ready  = (int'(count_reg) < DEPTH) && !flush;
  assign out_valid = (count_reg != '0) && !flush;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

// ===== card_command_tlv_transfer.sv
`timescale 1ns/1ps
module card_command_tlv_transfer
  import tlv_cmd_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Command header, one pulse per command.
  input  wire logic        hdr_valid,
  input  wire logic [1:0]  hdr_chan,
  input  wire logic [7:0]  hdr_ins,
  input  wire logic [7:0]  hdr_p1,
  input  wire logic [7:0]  hdr_p2,
  input  wire logic [7:0]  hdr_lc,
  input  wire logic        hdr_le_present,
  input  wire logic        app_supports_data,
  input  wire logic        proactive_pending,
  // Command data bytes.
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [7:0]  cmd_data,
  // Store data towards the file, through the buffer.
  output logic             store_valid,
  input  wire logic        store_ready,
  output logic [7:0]       store_data,
  // Object length known to the file for a retrieve.
  input  wire logic [23:0] file_obj_len,
  // Result of the command.
  output logic             rsp_valid,
  output logic [15:0]      rsp_sw,
  output logic [1:0]       rsp_kind,
  output logic [23:0]      rsp_tag,
  output logic             transfer_abort
);

  // ==========================================================================
  // Per-channel transfer context.
  logic [23:0]  tag_ptr_reg     [NUM_CHAN];
  logic [23:0]  offset_reg      [NUM_CHAN];
  logic [23:0]  obj_len_reg     [NUM_CHAN];
  logic         active_reg      [NUM_CHAN];
  logic         done_reg        [NUM_CHAN];
  logic         last_err_reg    [NUM_CHAN];
  logic [23:0]  prev_off_reg    [NUM_CHAN];

  cmd_state_t   state_reg;
  logic [1:0]   chan_reg;
  logic [7:0]   ins_reg;
  logic [7:0]   p1_reg;
  logic [7:0]   p2_reg;
  logic [7:0]   lc_reg;
  logic         le_reg;
  logic         supp_reg;
  logic         pro_reg;
  logic [7:0]   cnt_reg;
  logic [7:0]   hbuf_reg [8];
  logic [15:0]  sw_next;
  logic         ok_next;
  logic [23:0]  tag_next;
  logic [23:0]  len_next;
  logic [2:0]   tlen;
  logic [2:0]   llen;
  logic         tag_ok;
  logic         len_ok;
  logic         hdr_bad;
  logic [1:0]   blk;
  logic [4:0]   file_sel;
  logic [23:0]  seg_len;
  logic         fifo_in_ready;
  logic         fifo_out_valid;
  logic [7:0]   fifo_out_data;
  logic         is_store;
  logic         store_take;

  assign blk        = p2_reg[P2_BLK_HI:P2_BLK_LO];
  assign file_sel   = p2_reg[P2_FILE_HI:0];
  assign is_store   = (ins_reg == INS_STORE);
  assign store_take = is_store && supp_reg && (blk == BLK_NEXT
                      || (blk == BLK_FIRST && tag_ok && cnt_reg >= 8'(tlen + llen)));

  // ==========================================================================
  // Buffer between the command stream and the file store.
  tlv_byte_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) i_tlv_byte_fifo (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .in_valid  (cmd_valid && state_reg == ST_DATA && store_take),
    .in_ready  (fifo_in_ready),
    .in_data   (cmd_data),
    .out_valid (fifo_out_valid),
    .out_ready (store_ready && !store_valid),
    .out_data  (fifo_out_data),
    .flush     (transfer_abort)
  );

  assign cmd_ready  = (state_reg == ST_DATA) && !(store_take && !fifo_in_ready);

  // ==========================================================================
  // Tag and length field parsing of the first block.
  always_comb begin
    tlen   = 3'd1;
    tag_ok = 1'b0;
    tag_next = {16'h0000, hbuf_reg[0]};
    if (hbuf_reg[0] >= TAG_PRIM_LO && hbuf_reg[0] <= TAG_PRIM_HI) begin
      tag_ok = 1'b1;
    end else if (hbuf_reg[0] >= TAG_CONS_LO && hbuf_reg[0] <= TAG_CONS_HI) begin
      tag_ok = 1'b1;
    end else if (hbuf_reg[0] == TAG_LIST && !is_store) begin
      tag_ok = 1'b1;
    end else if (hbuf_reg[0] == TAG_PRIM_EXT || hbuf_reg[0] == TAG_CONS_EXT) begin
      if (hbuf_reg[1] >= TAG2_LO && hbuf_reg[1] <= TAG2_HI) begin
        tlen     = 3'd2;
        tag_ok   = 1'b1;
        tag_next = {8'h00, hbuf_reg[0], hbuf_reg[1]};
      end else if (hbuf_reg[1] >= TAG2_LONG_LO && hbuf_reg[2] <= TAG3_HI) begin
        tlen     = 3'd3;
        tag_ok   = 1'b1;
        tag_next = {hbuf_reg[0], hbuf_reg[1], hbuf_reg[2]};
      end
    end
  end

  always_comb begin
    llen     = 3'd1;
    len_ok   = 1'b1;
    len_next = {16'h0000, hbuf_reg[tlen]};
    if (hbuf_reg[tlen] <= LEN_SHORT_MAX) begin
      len_ok = 1'b1;
    end else if (hbuf_reg[tlen] == LEN_PFX1) begin
      llen     = 3'd2;
      len_next = {16'h0000, hbuf_reg[3'(tlen + 3'd1)]};
      len_ok   = hbuf_reg[3'(tlen + 3'd1)] > LEN_SHORT_MAX;
    end else if (hbuf_reg[tlen] == LEN_PFX2) begin
      llen     = 3'd3;
      len_next = {8'h00, hbuf_reg[3'(tlen + 3'd1)], hbuf_reg[3'(tlen + 3'd2)]};
      len_ok   = hbuf_reg[3'(tlen + 3'd1)] != 8'h00;
    end else if (hbuf_reg[tlen] == LEN_PFX3) begin
      llen     = 3'd4;
      len_next = {hbuf_reg[3'(tlen + 3'd1)], hbuf_reg[3'(tlen + 3'd2)], hbuf_reg[3'(tlen + 3'd3)]};
      len_ok   = hbuf_reg[3'(tlen + 3'd1)] != 8'h00;
    end else begin
      len_ok = 1'b0;
    end
  end

  // ==========================================================================
  // Header checks for the fixed commands.
  always_comb begin
    hdr_bad = 1'b0;
    if (ins_reg == INS_IDENTITY) begin
      hdr_bad = (p1_reg != P_ZERO);
    end else if (ins_reg == INS_PROFILE || ins_reg == INS_TERM_RESP) begin
      hdr_bad = (p1_reg != P_ZERO) || (p2_reg != P_ZERO) || le_reg;
    end else if (ins_reg == INS_ENVELOPE) begin
      hdr_bad = (p1_reg != P_ZERO) || (p2_reg != P_ZERO);
    end else if (ins_reg == INS_FETCH) begin
      hdr_bad = (p1_reg != P_ZERO) || (p2_reg != P_ZERO) || (lc_reg != 8'h00);
    end
  end

  assign seg_len = 24'(lc_reg);

  // ==========================================================================
  // Status decision for the command.
  always_comb begin
    sw_next = SW_OK;
    if (ins_reg == INS_RETRIEVE || ins_reg == INS_STORE) begin
      if (!supp_reg) begin
        sw_next = SW_NOT_SUPP;
      end else if (p1_reg != P_ZERO || blk == 2'h3) begin
        sw_next = SW_BAD_P1P2;
      end else if (blk != BLK_FIRST && file_sel != FILE_CURRENT) begin
        sw_next = SW_BAD_P1P2;
      end else if (blk == BLK_FIRST) begin
        if (!tag_ok || (is_store && !len_ok)) begin
          sw_next = SW_BAD_DATA;
        end else if (is_store) begin
          sw_next = (len_next > 24'(cnt_reg) - 24'(tlen) - 24'(llen)) ? SW_MORE_EXP : SW_OK;
        end else begin
          sw_next = (file_obj_len > 24'h0000FF) ? SW_MORE_AVAIL2 : SW_MORE_AVAIL;
        end
      end else if (blk == BLK_NEXT) begin
        if (done_reg[chan_reg] || !active_reg[chan_reg]) begin
          sw_next = SW_BAD_P1P2;
        end else if (is_store && offset_reg[chan_reg] + seg_len > obj_len_reg[chan_reg]) begin
          sw_next = SW_WRONG_LEN;
        end else if (is_store) begin
          sw_next = (offset_reg[chan_reg] + seg_len < obj_len_reg[chan_reg]) ? SW_MORE_EXP2 : SW_OK;
        end else begin
          sw_next = (offset_reg[chan_reg] + 24'h0000FF < obj_len_reg[chan_reg]) ? SW_MORE_AVAIL2 : SW_MORE_AVAIL;
        end
      end else begin
        if (last_err_reg[chan_reg] || !active_reg[chan_reg]) begin
          sw_next = SW_BAD_P1P2;
        end else begin
          sw_next = is_store ? SW_MORE_EXP : SW_MORE_AVAIL;
        end
      end
    end else if (hdr_bad) begin
      sw_next = SW_BAD_P1P2;
    end else if (pro_reg && ins_reg != INS_FETCH) begin
      sw_next = SW_PROACTIVE;
    end
    ok_next = (sw_next[15:8] == SW_OK[15:8]) || (sw_next[15:12] == 4'h6 && sw_next[7:4] == 4'hF)
              || (sw_next[15:8] == SW_PROACTIVE[15:8]);
  end

  // ==========================================================================
  // Command sequencing.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      chan_reg  <= 2'h0;
      ins_reg   <= 8'h00;
      p1_reg    <= 8'h00;
      p2_reg    <= 8'h00;
      lc_reg    <= 8'h00;
      le_reg    <= 1'b0;
      supp_reg  <= 1'b0;
      pro_reg   <= 1'b0;
      cnt_reg   <= 8'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (hdr_valid) begin
            chan_reg  <= hdr_chan;
            ins_reg   <= hdr_ins;
            p1_reg    <= hdr_p1;
            p2_reg    <= hdr_p2;
            lc_reg    <= hdr_lc;
            le_reg    <= hdr_le_present;
            supp_reg  <= app_supports_data;
            pro_reg   <= proactive_pending;
            cnt_reg   <= 8'h00;
            state_reg <= ST_HDR;
          end
        end
        ST_HDR: begin
          state_reg <= (lc_reg == 8'h00) ? ST_EXEC : ST_DATA;
        end
        ST_DATA: begin
          if (cmd_valid && cmd_ready) begin
            cnt_reg <= cnt_reg + 8'h01;
            if (cnt_reg + 8'h01 == lc_reg) begin
              state_reg <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          state_reg <= ST_ANSWER;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 8; i++) begin
        hbuf_reg[i] <= 8'h00;
      end
    end else if (state_reg == ST_DATA && cmd_valid && cmd_ready && cnt_reg < 8'h08) begin
      hbuf_reg[cnt_reg[2:0]] <= cmd_data;
    end else if (state_reg == ST_IDLE && hdr_valid) begin
      for (int i = 0; i < 8; i++) begin
        hbuf_reg[i] <= 8'h00;
      end
    end
  end

  // ==========================================================================
  // Per-channel context update.
  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    logic mine;
    assign mine = (state_reg == ST_EXEC) && (chan_reg == 2'(c));
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        tag_ptr_reg[c]  <= 24'h000000;
        offset_reg[c]   <= OFFSET_RESET;
        obj_len_reg[c]  <= 24'h000000;
        active_reg[c]   <= 1'b0;
        done_reg[c]     <= 1'b0;
        last_err_reg[c] <= 1'b0;
        prev_off_reg[c] <= OFFSET_RESET;
      end else if (mine) begin
        last_err_reg[c] <= !ok_next;
        if (ins_reg == INS_SELECT) begin
          active_reg[c] <= 1'b0;
          done_reg[c]   <= 1'b0;
        end else if (ok_next && (ins_reg == INS_RETRIEVE || ins_reg == INS_STORE)) begin
          if (blk == BLK_FIRST) begin
            tag_ptr_reg[c]  <= tag_next;
            obj_len_reg[c]  <= is_store ? len_next : file_obj_len;
            prev_off_reg[c] <= OFFSET_RESET;
            offset_reg[c]   <= is_store ? 24'(cnt_reg) - 24'(tlen) - 24'(llen) : 24'h0000FF;
            active_reg[c]   <= 1'b1;
            done_reg[c]     <= (sw_next == SW_OK) || (sw_next == SW_MORE_AVAIL);
          end else if (blk == BLK_NEXT) begin
            prev_off_reg[c] <= offset_reg[c];
            offset_reg[c]   <= offset_reg[c] + (is_store ? seg_len : 24'h0000FF);
            done_reg[c]     <= (sw_next == SW_OK) || (sw_next == SW_MORE_AVAIL);
          end
        end
      end
    end
  end

  // ==========================================================================
  // Outputs.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rsp_valid      <= 1'b0;
      rsp_sw         <= 16'h0000;
      rsp_kind       <= 2'h0;
      rsp_tag        <= 24'h000000;
      transfer_abort <= 1'b0;
    end else begin
      rsp_valid      <= (state_reg == ST_EXEC);
      transfer_abort <= (state_reg == ST_EXEC) && active_reg[chan_reg] && !done_reg[chan_reg]
                        && ((ins_reg == INS_SELECT) || (ok_next && blk == BLK_FIRST
                        && (ins_reg == INS_RETRIEVE || ins_reg == INS_STORE)));
      if (state_reg == ST_EXEC) begin
        rsp_sw   <= sw_next;
        rsp_kind <= blk;
        rsp_tag  <= (blk == BLK_FIRST && ok_next) ? tag_next : tag_ptr_reg[chan_reg];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      store_valid <= 1'b0;
      store_data  <= 8'h00;
    end else if (store_valid && store_ready) begin
      store_valid <= 1'b0;
    end else if (!store_valid && fifo_out_valid && store_ready) begin
      store_valid <= 1'b1;
      store_data  <= fifo_out_data;
    end
  end

endmodule

// ===== tlv_store_sink.sv
`timescale 1ns/1ps
module tlv_store_sink (
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // Store stream from the block.
  input  wire logic       store_valid,
  output logic            store_ready,
  input  wire logic [7:0] store_data,
  // What the file has received.
  output int              byte_count,
  output logic [7:0]      last_byte
);
  logic [1:0] pace_reg;
  // The file takes one byte in four cycles, so the buffer fills up.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pace_reg    <= 2'h0;
      store_ready <= 1'b0;
    end else begin
      pace_reg    <= pace_reg + 2'h1;
      store_ready <= (pace_reg == 2'h2);
    end
  end
  // Value bytes are counted and the last one is kept.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      byte_count <= 0;
      last_byte  <= 8'h00;
    end else if (store_valid && store_ready) begin
      byte_count <= byte_count + 1;
      last_byte  <= store_data;
    end
  end
endmodule

// ===== card_command_tlv_transfer_properties.sv
`timescale 1ns/1ps
module tlv_transfer_checker
  import tlv_cmd_pkg::*;
(
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        rstn,
  // Command header.
  input wire logic        hdr_valid,
  input wire logic [7:0]  hdr_ins,
  input wire logic [7:0]  hdr_p1,
  input wire logic [7:0]  hdr_p2,
  input wire logic [7:0]  hdr_lc,
  input wire logic        app_supports_data,
  // Store stream and result.
  input wire logic        store_valid,
  input wire logic        store_ready,
  input wire logic [7:0]  store_data,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_sw,
  input wire logic        transfer_abort
);
  logic       busy_reg, sup_reg, data_cmd, kit_cmd;
  logic [7:0] ins_reg, p1_reg, p2_reg;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ==========================================================================
  // Command in flight.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy_reg <= 1'b0;
    end else if (hdr_valid && !busy_reg) begin
      busy_reg <= 1'b1;
    end else if (rsp_valid) begin
      busy_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      {ins_reg, p1_reg, p2_reg, sup_reg} <= '0;
    end else if (hdr_valid && !busy_reg) begin
      {ins_reg, p1_reg, p2_reg, sup_reg} <= {hdr_ins, hdr_p1, hdr_p2, app_supports_data};
    end
  end
  assign data_cmd = (ins_reg == INS_RETRIEVE) || (ins_reg == INS_STORE);
  assign kit_cmd  = (ins_reg inside {INS_PROFILE, INS_ENVELOPE, INS_FETCH, INS_TERM_RESP});
  // ==========================================================================
  // Properties.
  AST_ANSWER_DELAY: assert property (hdr_valid && !busy_reg && hdr_lc == 8'h00 |-> !rsp_valid [*3] ##1 rsp_valid)
    else $error("answer to a header without data not three cycles later");
  AST_ANSWER_PULSE: assert property (rsp_valid |-> busy_reg ##1 !rsp_valid)
    else $error("answer outside a command or longer than one cycle");
  AST_KIT_PARAMS: assert property (rsp_valid && kit_cmd && (p1_reg != P_ZERO || p2_reg != P_ZERO) |-> rsp_sw != SW_OK)
    else $error("toolkit command with nonzero parameters accepted");
  AST_IDENT_P1: assert property (rsp_valid && ins_reg == INS_IDENTITY && p1_reg != P_ZERO |-> rsp_sw != SW_OK)
    else $error("identity query with nonzero first parameter accepted");
  AST_UNSUPPORTED: assert property (rsp_valid && data_cmd && !sup_reg |-> rsp_sw == SW_NOT_SUPP)
    else $error("unsupported data command not refused");
  AST_RFU_BLOCK: assert property (rsp_valid && data_cmd && sup_reg && p2_reg[7:6] == 2'b11 |-> rsp_sw == SW_BAD_P1P2)
    else $error("reserved block type not refused");
  AST_LATER_FILE: assert property (rsp_valid && data_cmd && sup_reg && p2_reg[7:6] != BLK_FIRST
                                   && p2_reg[4:0] != FILE_CURRENT |-> rsp_sw == SW_BAD_P1P2)
    else $error("later block on another file not refused");
  AST_STORE_HOLD: assert property (store_valid && !store_ready |=> store_valid && $stable(store_data))
    else $error("store byte dropped or changed while stalled");
  AST_ABORT_PULSE: assert property (transfer_abort |=> !transfer_abort)
    else $error("abort pulse longer than one cycle");
  COV_MORE_EXP: cover property (rsp_valid && rsp_sw == SW_MORE_EXP);
  COV_ABORT: cover property (transfer_abort);
  COV_STALL: cover property (store_valid && !store_ready);
endmodule
bind card_command_tlv_transfer tlv_transfer_checker i_chk (
  .clk_sys(clk_sys), .rstn(rstn), .hdr_valid(hdr_valid), .hdr_ins(hdr_ins), .hdr_p1(hdr_p1),
  .hdr_p2(hdr_p2), .hdr_lc(hdr_lc), .app_supports_data(app_supports_data), .store_valid(store_valid),
  .store_ready(store_ready), .store_data(store_data), .rsp_valid(rsp_valid), .rsp_sw(rsp_sw),
  .transfer_abort(transfer_abort)
);

// ===== card_command_tlv_transfer_tb.sv
`timescale 1ns/1ps
module card_command_tlv_transfer_tb import tlv_cmd_pkg::*;;
  logic clk_sys = 1'b0, rstn = 1'b0, hdr_valid = 1'b0, hdr_le_present = 1'b0, app_supports_data = 1'b1;
  logic proactive_pending = 1'b0, cmd_valid = 1'b0, cmd_ready, store_valid, store_ready, rsp_valid;
  logic transfer_abort, saw_abort;
  logic [1:0] hdr_chan = 2'h0, rsp_kind;
  logic [7:0] hdr_ins = 8'h00, hdr_p1 = 8'h00, hdr_p2 = 8'h00, hdr_lc = 8'h00, cmd_data = 8'h00, store_data, last_byte;
  logic [15:0] rsp_sw, sw;
  logic [23:0] rsp_tag, tag;
  logic [23:0] file_obj_len = 24'd300;
  logic [7:0] pay[$];
  int byte_count, num_errors = 0, total_checks = 0;
  always #5 clk_sys = ~clk_sys;
  card_command_tlv_transfer i_card_command_tlv_transfer (.clk_sys(clk_sys), .rstn(rstn), .hdr_valid(hdr_valid),
    .hdr_chan(hdr_chan), .hdr_ins(hdr_ins), .hdr_p1(hdr_p1), .hdr_p2(hdr_p2), .hdr_lc(hdr_lc),
    .hdr_le_present(hdr_le_present), .app_supports_data(app_supports_data), .proactive_pending(proactive_pending),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data), .store_valid(store_valid),
    .store_ready(store_ready), .store_data(store_data), .file_obj_len(file_obj_len), .rsp_valid(rsp_valid),
    .rsp_sw(rsp_sw), .rsp_kind(rsp_kind), .rsp_tag(rsp_tag), .transfer_abort(transfer_abort));
  tlv_store_sink i_tlv_store_sink (.clk_sys(clk_sys), .rstn(rstn), .store_valid(store_valid),
    .store_ready(store_ready), .store_data(store_data), .byte_count(byte_count), .last_byte(last_byte));
  always @(negedge clk_sys) if (transfer_abort === 1'b1) saw_abort = 1'b1;
  // ==========================================================================
  // Comparisons and closing.
  task automatic bad(input string msg);
    num_errors++;
    $display("BAD %0t %s", $time, msg);
  endtask
  task automatic check_sw(input logic [15:0] exp);
    total_checks++;
    if (sw !== exp) bad($sformatf("status %h expected %h", sw, exp));
  endtask
  task automatic check_word(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) bad($sformatf("value %h expected %h", got, exp));
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================================
  // One command: header, data bytes, then the answer.
  task automatic send(input logic [1:0] ch, input logic [7:0] ins, input logic [7:0] p1, input logic [7:0] p2);
    int k = 0, t = 0;
    logic hs;
    saw_abort = 1'b0;
    hdr_valid <= 1'b1;
    hdr_chan <= ch;
    hdr_ins <= ins;
    hdr_p1 <= p1;
    hdr_p2 <= p2;
    hdr_lc <= 8'(pay.size());
    @(posedge clk_sys);
    hdr_valid <= 1'b0;
    while (k < pay.size() && t < 2000) begin
      cmd_valid <= 1'b1;
      cmd_data <= pay[k];
      @(negedge clk_sys);
      hs = cmd_ready;
      @(posedge clk_sys);
      t++;
      if (hs === 1'b1) k++;
    end
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && t < 2000) begin
      @(negedge clk_sys);
      t++;
    end
    if (t >= 2000) bad("no answer");
    sw = rsp_sw;
    tag = rsp_tag;
    @(posedge clk_sys);
  endtask
  task automatic ramp(input int lo, input int hi);
    for (int i = lo; i < hi; i++) pay.push_back(8'(i));
  endtask
  // ==========================================================================
  // Scenarios.
  task automatic test_toolkit();
    logic [7:0] kit[5] = '{INS_PROFILE, INS_TERM_RESP, INS_ENVELOPE, INS_FETCH, INS_IDENTITY};
    for (int i = 0; i < 5; i++) begin
      pay = '{8'h01, 8'h02};
      if (i == 3) pay.delete();
      if (i < 2) begin
        send(2'h0, kit[i], 8'h00, 8'h00);
        check_sw(SW_OK);
      end
      send(2'h0, kit[i], 8'h01, 8'h00);
      check_sw(SW_BAD_P1P2);
    end
    proactive_pending <= 1'b1;
    send(2'h0, INS_ENVELOPE, 8'h00, 8'h00);
    check_sw(SW_PROACTIVE);
    proactive_pending <= 1'b0;
  endtask
  task automatic test_segments();
    pay = '{8'h9F, 8'h1F, 8'h81, 8'h80};
    ramp(0, 20);
    send(2'h0, INS_STORE, 8'h00, 8'h80);
    check_sw(SW_MORE_EXP);
    check_word(tag, 24'h009F1F);
    pay = '{};
    send(2'h0, INS_STORE, 8'h00, 8'h01);
    check_sw(SW_BAD_P1P2);
    check_word(tag, 24'h009F1F);
    send(2'h0, INS_STORE, 8'h00, 8'hC0);
    check_sw(SW_BAD_P1P2);
    send(2'h0, INS_STORE, 8'h00, 8'h40);
    check_sw(SW_BAD_P1P2);
    pay = '{8'h80};
    send(2'h1, INS_RETRIEVE, 8'h00, 8'h80);
    check_sw(SW_MORE_AVAIL2);
    pay = '{};
    ramp(20, 128);
    send(2'h0, INS_STORE, 8'h00, 8'h00);
    check_sw(SW_OK);
    for (int i = 0; i < 1000 && byte_count < 128; i++) @(posedge clk_sys);
    check_word(24'(byte_count), 24'd128);
    check_word({16'h0, last_byte}, 24'h00007F);
    pay = '{};
    send(2'h0, INS_STORE, 8'h00, 8'h00);
    check_sw(SW_BAD_P1P2);
    send(2'h1, INS_RETRIEVE, 8'h00, 8'h00);
    check_sw(SW_MORE_AVAIL);
    send(2'h1, INS_RETRIEVE, 8'h00, 8'h00);
    check_sw(SW_BAD_P1P2);
  endtask
  task automatic test_tags();
    pay = '{8'h9F, 8'h10, 8'h00};
    send(2'h0, INS_STORE, 8'h00, 8'h80);
    check_sw(SW_BAD_DATA);
    pay = '{8'hC0, 8'h00};
    send(2'h0, INS_STORE, 8'h00, 8'h80);
    check_sw(SW_BAD_DATA);
    pay = '{8'hBF, 8'h1F, 8'h00};
    send(2'h0, INS_STORE, 8'h00, 8'h80);
    check_sw(SW_OK);
    app_supports_data <= 1'b0;
    send(2'h0, INS_STORE, 8'h00, 8'h80);
    check_sw(SW_NOT_SUPP);
    app_supports_data <= 1'b1;
    pay = '{8'h5C, 8'h00};
    send(2'h0, INS_STORE, 8'h00, 8'h80);
    check_sw(SW_BAD_DATA);
  endtask
  task automatic test_abort();
    pay = '{8'h80, 8'h05, 8'h11};
    send(2'h2, INS_STORE, 8'h00, 8'h80);
    check_sw(SW_MORE_EXP);
    send(2'h2, INS_STORE, 8'h00, 8'h40);
    check_sw(SW_MORE_EXP);
    check_word(24'(rsp_kind), 24'(BLK_RETX));
    send(2'h2, INS_STORE, 8'h00, 8'h80);
    check_word({23'h0, saw_abort}, 24'h000001);
    pay = '{};
    send(2'h2, INS_SELECT, 8'h00, 8'h00);
    check_word({23'h0, saw_abort}, 24'h000001);
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad("watchdog expired");
    finish_test();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    test_toolkit();
    test_segments();
    test_tags();
    test_abort();
    finish_test();
  end
endmodule
